/* fault_manager.sv */
`timescale 1ns/100ps
module fault_manager
  import fault_pkg::*;
#(
  parameter int N_FET = 6
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic vm_uvlo_i,
  input wire logic analog_regulator_rail_uv_i,
  input wire logic buck_feedback_pin_uv_i,
  input wire logic charge_pump_rail_uv_i,
  input wire logic vm_above_low_i,
  input wire logic vm_above_high_i,
  input wire logic [N_FET-1:0] fet_over_i,
  input wire logic buck_over_i,
  input wire logic bus_over_cap_i,
  input wire logic cur_loop_sat_i,
  input wire logic spd_loop_sat_i,
  output logic fault_out_low_o,
  output logic fets_hiz_o,
  output logic speed_limit_o,
  output logic buck_off_o,
  output logic pump_off_o,
  output logic reset_req_o
);
  localparam int N_ASYNC = N_FET + 7;

  generate
    if (N_FET < 1 || N_FET > 16) begin : g_bad_fet
      $error("N_FET must be 1 to 16");
    end
  endgenerate

  typedef struct packed {
    logic [N_ASYNC-1:0] sync1;
    logic [N_ASYNC-1:0] sync2;
    logic [31:0] cfg;
    logic [15:0] wdt_int;
    logic [15:0] retry;
    logic [7:0] prescale;
    logic [15:0] wdt_cnt;
    logic [15:0] retry_cnt;
    oc_state_t oc_state;
    logic wdt_flag;
    logic wdt_hiz;
    logic pump_flag;
    logic ov_flag;
    logic oc_flag;
    logic [N_FET-1:0] fet_flag;
    logic [31:0] rdata;
    logic fault_n;
    logic hiz;
    logic speed_lim;
    logic buck_off;
    logic pump_off;
    logic rst_req;
  } mgr_state_t;

  mgr_state_t s;
  mgr_state_t next_s;

  logic [N_FET:0] filt_in;
  logic [N_FET:0] filt_hit;

  // synced pins: fet bits, buck oc, then the supply monitors
  assign filt_in = s.sync2[N_FET:0];

  // deglitch each fet and the buck switch
  genvar gi;
  generate
    for (gi = 0; gi <= N_FET; gi++) begin : g_filt
      glitch_filter #(.CNT_W(8)) u_filt (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .level_i(filt_in[gi]),
        .limit_i(s.cfg[CFG_FILT +: 8]),
        .hit_o(filt_hit[gi])
      );
    end
  endgenerate

  logic vm_uv;
  logic analog_regulator_rail_uv;
  logic bk_uv;
  logic pump_uv;
  logic ov_low;
  logic ov_high;
  logic clr;
  logic tickle;
  logic tick;
  logic lockout;
  logic buck_lock;
  logic ov_live;
  logic oc_live;
  logic oc_event;
  logic wdt_expire;
  logic retry_done;
  logic bus_live;
  logic csat_live;
  logic ssat_live;
  logic drv_fault;
  logic ctrl_fault;
  oc_action_t oc_act;

  always_comb begin
    vm_uv = s.sync2[N_FET+1];
    analog_regulator_rail_uv = s.sync2[N_FET+2];
    bk_uv = s.sync2[N_FET+3];
    pump_uv = s.sync2[N_FET+4];
    ov_low = s.sync2[N_FET+5];
    ov_high = s.sync2[N_FET+6];
    oc_act = oc_action_t'(s.cfg[CFG_OC_ACT +: 2]);
    // clear acts on the write cycle only
    clr = wr_i && addr_i == CMD_ADDR && wdata_i[CMD_CLEAR];
    tickle = wr_i && addr_i == CMD_ADDR && wdata_i[CMD_TICKLE];
    tick = s.prescale == TICK_LAST;
    // filtered buck overcurrent joins the lockouts
    buck_lock = bk_uv || filt_hit[N_FET];
    lockout = vm_uv || analog_regulator_rail_uv || buck_lock;
    // guard enable and trip level pick
    ov_live = s.cfg[CFG_OV_ON] &&
      (s.cfg[CFG_OV_PICK] ? ov_high : ov_low);
    oc_live = |filt_hit[N_FET-1:0];
    // action 11 never raises an event
    oc_event = oc_live && oc_act != OC_OFF;
    wdt_expire = s.cfg[CFG_WDT_ON] && s.wdt_cnt >= s.wdt_int;
    retry_done = tick && s.retry_cnt >= s.retry;
    // bus cap enable gates the live condition
    bus_live = s.cfg[CFG_BUS_EN] && bus_over_cap_i;
    csat_live = s.cfg[CFG_SAT_EN] && cur_loop_sat_i;
    ssat_live = s.cfg[CFG_SAT_EN] && spd_loop_sat_i;
    drv_fault = pump_uv || ov_live || s.oc_state != OCS_IDLE;
    ctrl_fault = s.wdt_flag || bus_live || csat_live || ssat_live;
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = {ov_high_pin(vm_above_high_i), vm_above_low_i,
      charge_pump_rail_uv_i, buck_feedback_pin_uv_i,
      analog_regulator_rail_uv_i, vm_uvlo_i, buck_over_i, fet_over_i};
    next_s.sync2 = s.sync1;
    next_s.prescale = tick ? 8'h00 : s.prescale + 8'h01;

    if (wr_i) begin
      unique case (addr_i)
        CFG_ADDR: next_s.cfg = wdata_i;
        WDT_ADDR: next_s.wdt_int = wdata_i[15:0];
        RETRY_ADDR: next_s.retry = wdata_i[15:0];
        default: ;
      endcase
    end

    // watchdog counts microseconds since last tickle
    if (!s.cfg[CFG_WDT_ON] || tickle) begin
      next_s.wdt_cnt = 16'h0000;
    end else if (tick && !wdt_expire) begin
      next_s.wdt_cnt = s.wdt_cnt + 16'h0001;
    end
    if (clr && !wdt_expire) begin
      next_s.wdt_flag = 1'b0;
      next_s.wdt_hiz = 1'b0;
      next_s.wdt_cnt = 16'h0000;
    end
    // set wins over a clear in the same cycle
    if (wdt_expire) begin
      next_s.wdt_flag = 1'b1;
      next_s.wdt_hiz = s.cfg[CFG_WDT_ACT];
    end

    if (clr && !pump_uv) begin
      next_s.pump_flag = 1'b0;
    end
    if (clr && !ov_live) begin
      next_s.ov_flag = 1'b0;
    end
    if (pump_uv) begin
      next_s.pump_flag = 1'b1;
    end
    if (ov_live) begin
      next_s.ov_flag = 1'b1;
    end

    // overcurrent flags stay until a clear or a lockout
    if (clr && !oc_live) begin
      next_s.oc_flag = 1'b0;
    end
    if (clr) begin
      next_s.fet_flag = s.fet_flag & filt_hit[N_FET-1:0];
    end
    if (oc_event) begin
      next_s.oc_flag = 1'b1;
      next_s.fet_flag = next_s.fet_flag | filt_hit[N_FET-1:0];
    end

    unique case (s.oc_state)
      OCS_IDLE: begin
        next_s.retry_cnt = 16'h0000;
        if (oc_event) begin
          unique case (oc_act)
            OC_LATCH: next_s.oc_state = OCS_LATCHED;
            OC_RETRY: next_s.oc_state = OCS_WAIT;
            OC_REPORT: next_s.oc_state = OCS_REPORTED;
            OC_OFF: next_s.oc_state = OCS_IDLE;
          endcase
        end
      end
      // leave only on clear with condition gone, or on a lockout
      OCS_LATCHED, OCS_REPORTED: begin
        if (clr && !oc_live) begin
          next_s.oc_state = OCS_IDLE;
        end
      end
      // retry timer, driver fault ends at expiry
      OCS_WAIT: begin
        if (retry_done) begin
          next_s.oc_state = OCS_IDLE;
        end else if (tick) begin
          next_s.retry_cnt = s.retry_cnt + 16'h0001;
        end
      end
    endcase

    // lockouts put the logic in reset
    if (lockout) begin
      next_s.wdt_cnt = 16'h0000;
      next_s.retry_cnt = 16'h0000;
      next_s.oc_state = OCS_IDLE;
      next_s.wdt_flag = 1'b0;
      next_s.wdt_hiz = 1'b0;
      next_s.pump_flag = 1'b0;
      next_s.ov_flag = 1'b0;
      next_s.oc_flag = 1'b0;
      next_s.fet_flag = '0;
    end

    next_s.hiz = lockout || pump_uv || ov_live || next_s.wdt_hiz ||
      next_s.oc_state == OCS_LATCHED || next_s.oc_state == OCS_WAIT;
    next_s.pump_off = vm_uv || analog_regulator_rail_uv;
    next_s.buck_off = buck_lock;
    next_s.rst_req = lockout;
    // speed restriction tracks the live condition
    next_s.speed_lim = bus_live && !lockout;
    // new watchdog flag pulls the pin in the same edge as the float
    next_s.fault_n = lockout || !(drv_fault || ctrl_fault ||
      next_s.wdt_flag || next_s.oc_state != OCS_IDLE);

    next_s.rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        CFG_ADDR: next_s.rdata = s.cfg;
        WDT_ADDR: next_s.rdata = {16'h0000, s.wdt_int};
        RETRY_ADDR: next_s.rdata = {16'h0000, s.retry};
        STAT_ADDR: begin
          next_s.rdata[ST_CTRL] = ctrl_fault;
          next_s.rdata[ST_DRV] = drv_fault;
          next_s.rdata[ST_WDT] = s.wdt_flag;
          next_s.rdata[ST_BUS] = bus_live;
          next_s.rdata[ST_CSAT] = csat_live;
          next_s.rdata[ST_SSAT] = ssat_live;
          next_s.rdata[ST_PUMP] = s.pump_flag;
          next_s.rdata[ST_OV] = s.ov_flag;
          next_s.rdata[ST_OC] = s.oc_flag;
          next_s.rdata[ST_LOCK] = lockout;
        end
        FET_ADDR: next_s.rdata[N_FET-1:0] = s.fet_flag;
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  function automatic logic ov_high_pin(input logic v);
    ov_high_pin = v;
  endfunction

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.wdt_int <= WDT_RESET;
      s.retry <= RETRY_RESET;
      s.fault_n <= 1'b1;
      s.oc_state <= OCS_IDLE;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign fault_out_low_o = s.fault_n;
  assign fets_hiz_o = s.hiz;
  assign speed_limit_o = s.speed_lim;
  assign buck_off_o = s.buck_off;
  assign pump_off_o = s.pump_off;
  assign reset_req_o = s.rst_req;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  sequence retry_start_s;
    ce_i && s.oc_state == OCS_IDLE && oc_event && oc_act == OC_RETRY &&
      !lockout;
  endsequence

  sequence retry_hold_s;
    fets_hiz_o && !fault_out_low_o && s.oc_state == OCS_WAIT;
  endsequence

  watchdog_hiz_a: assert property (
    (ce_i && wdt_expire && s.cfg[CFG_WDT_ACT] && !lockout) |=>
      fets_hiz_o && !fault_out_low_o)
    else $error("watchdog timeout did not float outputs");

  bus_cap_a: assert property (
    (ce_i && !lockout) |=> speed_limit_o == $past(bus_live))
    else $error("speed restriction not following bus cap");

  sat_report_a: assert property (
    (ce_i && csat_live && !lockout) |=> !fault_out_low_o)
    else $error("loop saturation not reported");

  lockout_reset_a: assert property (
    (ce_i && (vm_uv || analog_regulator_rail_uv)) |=>
      reset_req_o && fets_hiz_o && pump_off_o && !s.ov_flag)
    else $error("supply lockout did not reset");

  buck_stop_a: assert property (
    (ce_i && buck_lock) |=> buck_off_o && reset_req_o)
    else $error("buck lockout did not stop buck");

  pump_sticky_a: assert property (
    (ce_i && s.pump_flag && !clr && !lockout) |=> s.pump_flag)
    else $error("pump low flag lost without clear");

  ov_trip_a: assert property (
    (ce_i && ov_live && !lockout) |=> fets_hiz_o && s.ov_flag)
    else $error("overvoltage did not disable fets");

  ov_guard_a: assert property (
    (ce_i && !s.cfg[CFG_OV_ON] && !s.ov_flag) |=> !s.ov_flag)
    else $error("overvoltage flag set while guard off");

  latch_hold_a: assert property (
    (ce_i && s.oc_state == OCS_LATCHED && !clr && !lockout) |=>
      s.oc_state == OCS_LATCHED && fets_hiz_o)
    else $error("latched overcurrent released early");

  retry_enter_a: assert property (
    retry_start_s |=> retry_hold_s)
    else $error("retry mode did not float fets");

  oc_ignore_a: assert property (
    (ce_i && oc_act == OC_OFF && !s.oc_flag) |=> !s.oc_flag)
    else $error("overcurrent flag set while ignored");

  clear_keep_a: assert property (
    (ce_i && clr && ov_live && !lockout) |=> s.ov_flag)
    else $error("clear dropped a live overvoltage flag");
endmodule

/* fault_manager_test.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
  err_total++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module fault_manager_test;
  import fault_pkg::*;
  logic mclk_i;
  logic reset_i;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [3:0] lk;
  logic [2:0] lv;
  logic [5:0] fo;
  logic vl;
  logic vh;
  logic cp;
  logic flow;
  logic hiz;
  logic spd;
  logic bk;
  logic pmp;
  logic rq;
  logic ce;
  int err_total = 0;
  int n_tests = 0;
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  fault_manager uut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .vm_uvlo_i(lk[0]), .analog_regulator_rail_uv_i(lk[1]),
    .buck_feedback_pin_uv_i(lk[2]), .charge_pump_rail_uv_i(cp),
    .vm_above_low_i(vl), .vm_above_high_i(vh), .fet_over_i(fo),
    .buck_over_i(lk[3]), .bus_over_cap_i(lv[0]), .cur_loop_sat_i(lv[1]),
    .spd_loop_sat_i(lv[2]), .fault_out_low_o(flow), .fets_hiz_o(hiz),
    .speed_limit_o(spd), .buck_off_o(bk), .pump_off_o(pmp),
    .reset_req_o(rq));
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    host.get(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // run is about 5500 cycles, cut off far beyond that
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    reset_i = 1'b1;
    {lk, lv, fo, vl, vh, cp} = '0;
    ce = 1'b1;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    rchk("cfg", CFG_ADDR, CFG_RESET);
    rchk("wdt", WDT_ADDR, {16'h0000, WDT_RESET});
    rchk("retry", RETRY_ADDR, {16'h0000, RETRY_RESET});
    host.put(STAT_ADDR, 32'hFFFF_FFFF);
    rchk("stat ro", STAT_ADDR, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    `CHK("pin idle", 1'b1, flow)
    @(posedge mclk_i) vl <= 1'b1;
    wt(4);
    `CHK("ov hiz", 1'b1, hiz)
    `CHK("ov pin", 1'b0, flow)
    rchk("ov stat", STAT_ADDR, 32'h82);
    host.clear();
    rchk("ov live clr", STAT_ADDR, 32'h82);
    @(posedge mclk_i) vl <= 1'b0;
    wt(4);
    `CHK("ov off", 1'b0, hiz)
    rchk("ov sticky", STAT_ADDR, 32'h80);
    host.clear();
    rchk("ov clr", STAT_ADDR, 32'h0);
    host.put(CFG_ADDR, 32'h0A30);
    @(posedge mclk_i) vl <= 1'b1;
    wt(4);
    `CHK("hi level", 1'b0, hiz)
    @(posedge mclk_i) vh <= 1'b1;
    wt(4);
    `CHK("hi trip", 1'b1, hiz)
    host.put(CFG_ADDR, 32'h0A00);
    host.clear();
    wt(4);
    `CHK("guard off", 1'b0, hiz)
    rchk("guard stat", STAT_ADDR, 32'h0);
    @(posedge mclk_i) {vl, vh, cp} <= 3'b001;
    wt(4);
    `CHK("pump hiz", 1'b1, hiz)
    rchk("pump stat", STAT_ADDR, 32'h42);
    @(posedge mclk_i) cp <= 1'b0;
    wt(4);
    `CHK("pump off", 1'b0, hiz)
    rchk("pump sticky", STAT_ADDR, 32'h40);
    host.clear();
    rchk("pump clr", STAT_ADDR, 32'h0);
    host.put(RETRY_ADDR, 32'h1);
    // filter limit 2: a two-cycle glitch is too short
    host.put(CFG_ADDR, 32'h0210);
    @(posedge mclk_i) fo <= 6'h04;
    @(posedge mclk_i);
    @(posedge mclk_i) fo <= 6'h00;
    wt(8);
    rchk("glitch", STAT_ADDR, 32'h0);
    for (int a = 0; a < 4; a++) begin
      host.put(CFG_ADDR, 32'h0210 | (a << 6));
      @(posedge mclk_i) fo <= 6'h04;
      wt(10);
      `CHK("oc hiz", (a < 2), hiz)
      rchk("oc stat", STAT_ADDR, (a == 3) ? 32'h0 : 32'h102);
      rchk("oc fet", FET_ADDR, (a == 3) ? 32'h0 : 32'h4);
      @(posedge mclk_i) fo <= 6'h00;
      wt(600);
      `CHK("oc after", (a == 0), hiz)
      rchk("oc keep", STAT_ADDR,
           (a == 3) ? 32'h0 : (a == 1) ? 32'h100 : 32'h102);
      rchk("oc fet keep", FET_ADDR, (a == 3) ? 32'h0 : 32'h4);
      host.clear();
      wt(2);
      `CHK("oc clr hiz", 1'b0, hiz)
      rchk("oc clr", STAT_ADDR, 32'h0);
    end
    host.put(WDT_ADDR, 32'h2);
    host.put(CFG_ADDR, 32'h0A11);
    repeat (4) begin
      wt(150);
      host.put(CMD_ADDR, 32'h0000_0002);
    end
    rchk("wdt fed", STAT_ADDR, 32'h0);
    for (int a = 0; a < 2; a++) begin
      host.put(CFG_ADDR, 32'h0A11 | (a << 1));
      wt(1000);
      `CHK("wdt hiz", a[0], hiz)
      `CHK("wdt pin", 1'b0, flow)
      rchk("wdt stat", STAT_ADDR, 32'h5);
      host.put(CFG_ADDR, 32'h0A10);
      host.clear();
      wt(2);
      `CHK("wdt rel", 1'b0, hiz)
    end
    host.put(CFG_ADDR, 32'h0A1C);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i) lv <= 3'(1 << i);
      wt(4);
      `CHK("live spd", (i == 0), spd)
      `CHK("live pin", 1'b0, flow)
      `CHK("live hiz", 1'b0, hiz)
      rchk("live stat", STAT_ADDR, 32'h1 | (32'h8 << i));
      @(posedge mclk_i) lv <= 3'b000;
      wt(4);
      `CHK("live spd off", 1'b0, spd)
      rchk("live gone", STAT_ADDR, 32'h0);
    end
    @(posedge mclk_i) {ce, vl} <= 2'b01;
    wt(8);
    `CHK("ce hold", 1'b0, hiz)
    @(posedge mclk_i) ce <= 1'b1;
    wt(4);
    `CHK("ce run", 1'b1, hiz)
    @(posedge mclk_i) vl <= 1'b0;
    wt(4);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i) lk <= 4'(1 << i);
      wt(20);
      `CHK("lock req", 1'b1, rq)
      if (i < 2) begin
        `CHK("lock fets", 2'b11, {hiz, pmp})
      end else begin
        `CHK("lock buck", 1'b1, bk)
      end
      @(posedge mclk_i) lk <= 4'h0;
      wt(20);
      `CHK("lock rel", 1'b0, rq)
    end
    tally_and_finish();
  end
endmodule

/* fault_pkg.sv */
`timescale 1ns/100ps
package fault_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] CMD_ADDR = 8'h04;
  localparam logic [7:0] WDT_ADDR = 8'h08;
  localparam logic [7:0] RETRY_ADDR = 8'h0C;
  localparam logic [7:0] STAT_ADDR = 8'h10;
  localparam logic [7:0] FET_ADDR = 8'h14;

  localparam int CFG_WDT_ON = 0;
  localparam int CFG_WDT_ACT = 1;
  localparam int CFG_BUS_EN = 2;
  localparam int CFG_SAT_EN = 3;
  localparam int CFG_OV_ON = 4;
  localparam int CFG_OV_PICK = 5;
  localparam int CFG_OC_ACT = 6;
  localparam int CFG_FILT = 8;

  localparam int CMD_CLEAR = 0;
  localparam int CMD_TICKLE = 1;

  localparam int ST_CTRL = 0;
  localparam int ST_DRV = 1;
  localparam int ST_WDT = 2;
  localparam int ST_BUS = 3;
  localparam int ST_CSAT = 4;
  localparam int ST_SSAT = 5;
  localparam int ST_PUMP = 6;
  localparam int ST_OV = 7;
  localparam int ST_OC = 8;
  localparam int ST_LOCK = 9;

  localparam logic [31:0] CFG_RESET = 32'h0000_0A10;
  localparam logic [15:0] WDT_RESET = 16'h03E8;
  localparam logic [15:0] RETRY_RESET = 16'h01F4;

  typedef enum logic [1:0] {
    OC_LATCH = 2'b00,
    OC_RETRY = 2'b01,
    OC_REPORT = 2'b10,
    OC_OFF = 2'b11
  } oc_action_t;

  typedef enum logic [1:0] {
    OCS_IDLE = 2'b00,
    OCS_LATCHED = 2'b01,
    OCS_WAIT = 2'b10,
    OCS_REPORTED = 2'b11
  } oc_state_t;
endpackage

module glitch_filter #(
  parameter int CNT_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic level_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic hit_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic hit;
  } filt_state_t;

  filt_state_t s;
  filt_state_t next_s;

  generate
    if (CNT_W < 1) begin : g_bad_width
      $error("CNT_W must be at least 1");
    end
  endgenerate

  always_comb begin
    next_s = s;
    if (!level_i) begin
      next_s.cnt = '0;
      next_s.hit = 1'b0;
    end else if (s.cnt == limit_i) begin
      next_s.hit = 1'b1;
    end else begin
      next_s.cnt = s.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign hit_o = s.hit;

  // a hit stays set while the level is still held
  held_hit_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && s.hit && level_i) |=> s.hit)
    else $error("filter dropped a held level");
endmodule

/* host_model.sv */
`timescale 1ns/100ps
module host_model (
  input wire logic mclk_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  import fault_pkg::*;
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    // no stale data left on an idle bus
    wdata_o <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    @(negedge mclk_i);
    d = rdata_i;
  endtask
  task automatic clear();
    put(CMD_ADDR, 32'h0000_0001);
  endtask
endmodule
